// ### verilog/eisc_top.sv
// External interrupt pin sense, status flags and AXI4-Lite registers.
// Assumes pins synchronous to aclk; handling acks come from the CPU side.
//
// Function
// - Two trigger-select bits per pin, pin n bits 2n+1:2n
// - Code 00 requests while pin is low
// - Code 01 requests on falling edge
// - Code 10 requests on rising edge
// - Code 11 requests on both edges
// - Selected condition sets flag n
// - Flag clears by write 0 after reading 1
// - Level mode: handling clears flag if pin high
// - Edge modes: handling clears flag unless a new edge arrives in the same cycle
// - Request forwarded only when pin enabled
// - Detection independent of pin direction
`timescale 1ns/1ps
module eisc_top
  import eisc_pkg::*;
#(
  parameter int PINS = EISC_PINS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [EISC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [EISC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External interrupt pins and handling acknowledges
  input wire logic [PINS-1:0] ext_int_pin,
  input wire logic [PINS-1:0] handling_ack,
  // Requests toward arbitration, and summary interrupt
  output logic [PINS-1:0] pin_request_q,
  output logic irq_q
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [2*PINS-1:0] trig_q;
  logic [PINS-1:0] flags_q;
  logic [PINS-1:0] seen_one_q;
  logic [PINS-1:0] enab_q;
  logic [PINS-1:0] mask_q;
  logic [PINS-1:0] pin_q;
  logic [PINS-1:0] pin_prev_q;
  logic [PINS-1:0] event_w;
  logic [PINS-1:0] hw_clr_w;
  logic [EISC_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic do_wr;
  logic do_rd;
  eisc_rd_t rd_w;

  // ----------------------------------------------------------------
  // Pin sampling and detection
  // ----------------------------------------------------------------

  // Sample and previous sample; pin direction plays no part
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= {PINS{1'b1}};
      pin_prev_q <= {PINS{1'b1}};
    end else begin
      pin_q <= ext_int_pin;
      pin_prev_q <= pin_q;
    end
  end

  // Per-pin trigger decode
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      eisc_sense_t sel;
      logic fall;
      logic rise;
      assign sel = eisc_sense_t'(trig_q[2*g +: 2]);
      assign fall = pin_prev_q[g] & ~pin_q[g];
      assign rise = ~pin_prev_q[g] & pin_q[g];
      always_comb begin
        case (sel)
          EISC_LOW: event_w[g] = ~pin_q[g];
          EISC_FALL: event_w[g] = fall;
          EISC_RISE: event_w[g] = rise;
          default: event_w[g] = fall | rise;
        endcase
        // Level mode keeps the flag while the pin is still low
        if (sel == EISC_LOW) begin
          hw_clr_w[g] = handling_ack[g] & pin_q[g];
        end else begin
          hw_clr_w[g] = handling_ack[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign do_rd = s_axi_arvalid & s_axi_arready;

  // Address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~do_wr;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & ~do_wr;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= EISC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q == EISC_OFS_TRIG || awaddr_q == EISC_OFS_FLAGS ||
          awaddr_q == EISC_OFS_ENAB || awaddr_q == EISC_OFS_MASK) begin
        s_axi_bresp <= EISC_RESP_OKAY;
      end else begin
        s_axi_bresp <= EISC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; trigger field spans byte lanes 0 and 1, enable and mask sit in lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= EISC_TRIG_RST;
      enab_q <= EISC_PIN_RST;
      mask_q <= EISC_PIN_RST;
    end else if (do_wr) begin
      if (awaddr_q == EISC_OFS_TRIG) begin
        if (wstrb_q[0]) trig_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) trig_q[2*PINS-1:8] <= wdata_q[2*PINS-1:8];
      end else if (awaddr_q == EISC_OFS_ENAB) begin
        if (wstrb_q[0]) enab_q <= wdata_q[PINS-1:0];
      end else if (awaddr_q == EISC_OFS_MASK) begin
        if (wstrb_q[0]) mask_q <= wdata_q[PINS-1:0];
      end
    end
  end

  // Flags: set wins over every clear so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= EISC_PIN_RST;
      seen_one_q <= EISC_PIN_RST;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (event_w[i]) begin
          flags_q[i] <= 1'b1;
        end else if (hw_clr_w[i]) begin
          flags_q[i] <= 1'b0;
        end else if (do_wr && awaddr_q == EISC_OFS_FLAGS && wstrb_q[0] &&
                     !wdata_q[i] && seen_one_q[i]) begin
          flags_q[i] <= 1'b0;
        end
        // Arm the clear only after a read that returned one
        if (do_rd && s_axi_araddr == EISC_OFS_FLAGS && flags_q[i]) begin
          seen_one_q[i] <= 1'b1;
        end else if (!flags_q[i] ||
                     (do_wr && awaddr_q == EISC_OFS_FLAGS && wstrb_q[0])) begin
          seen_one_q[i] <= 1'b0;
        end
      end
    end
  end

  // Read mux; unused bits read as zero, software writes them as zero
  always_comb begin
    rd_w.data = '0;
    rd_w.resp = EISC_RESP_OKAY;
    if (s_axi_araddr == EISC_OFS_TRIG) begin
      rd_w.data[2*PINS-1:0] = trig_q;
    end else if (s_axi_araddr == EISC_OFS_FLAGS) begin
      rd_w.data[PINS-1:0] = flags_q;
    end else if (s_axi_araddr == EISC_OFS_ENAB) begin
      rd_w.data[PINS-1:0] = enab_q;
    end else if (s_axi_araddr == EISC_OFS_MASK) begin
      rd_w.data[PINS-1:0] = mask_q;
    end else begin
      rd_w.resp = EISC_RESP_SLVERR;
    end
  end

  // Read channel: one read outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= EISC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~do_rd;
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_w.data;
        s_axi_rresp <= rd_w.resp;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Request only while the pin is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_request_q <= '0;
      irq_q <= 1'b0;
    end else begin
      pin_request_q <= flags_q & enab_q;
      irq_q <= |(flags_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_flag_set_event: assert property (event_w[0] |=> flags_q[0])
    else $error("flag 0 not set after event");
  a_fall_detect: assert property (
    trig_q[3:2] == EISC_FALL && $fell(pin_q[1]) |-> event_w[1])
    else $error("falling edge missed on pin 1");
  a_rise_detect: assert property (
    trig_q[5:4] == EISC_RISE && $rose(pin_q[2]) |-> event_w[2])
    else $error("rising edge missed on pin 2");
  a_both_detect: assert property (
    trig_q[7:6] == EISC_BOTH && pin_q[3] != pin_prev_q[3]
    |-> event_w[3])
    else $error("edge missed on pin 3 in both mode");
  a_low_level: assert property (
    trig_q[1:0] == EISC_LOW && !pin_q[0] |=> flags_q[0])
    else $error("low level not flagged on pin 0");
  a_level_hold: assert property (
    trig_q[1:0] == EISC_LOW && handling_ack[0] && !pin_q[0]
    |=> flags_q[0])
    else $error("level flag cleared while pin low");
  a_edge_clear: assert property (
    trig_q[3:2] != EISC_LOW && handling_ack[1] && !event_w[1]
    |=> !flags_q[1])
    else $error("edge flag not cleared by handling");
  a_blind_write: assert property (
    flags_q[0] && !seen_one_q[0] && !hw_clr_w[0] |=> flags_q[0])
    else $error("flag cleared without prior read of one");
  a_req_enable: assert property (
    !enab_q[0] |=> !pin_request_q[0])
    else $error("request forwarded from disabled pin");
  a_sample_delay: assert property (
    ##1 pin_prev_q == $past(pin_q))
    else $error("previous sample mismatch");

  c_read_clear: cover property (seen_one_q[0] ##[1:20] !flags_q[0]);
  c_edge_ack: cover property (flags_q[1] ##1 handling_ack[1]);
  c_irq_out: cover property ($rose(irq_q));
  c_both_edges: cover property (event_w[3] ##[1:200] event_w[3]);

endmodule

// ### verilog/eisc_pkg.sv
// Package for the external pin interrupt sense and status block.
// Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
package eisc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int EISC_PINS = 6;
  localparam int EISC_SEL_W = 2;
  localparam int EISC_ADDR_W = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [EISC_ADDR_W-1:0] EISC_OFS_TRIG = 4'h0;
  localparam logic [EISC_ADDR_W-1:0] EISC_OFS_FLAGS = 4'h4;
  localparam logic [EISC_ADDR_W-1:0] EISC_OFS_ENAB = 4'h8;
  localparam logic [EISC_ADDR_W-1:0] EISC_OFS_MASK = 4'hC;

  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int EISC_TRIG_W = 16;
  localparam int EISC_FLAG_W = 8;
  localparam logic [EISC_PINS*EISC_SEL_W-1:0] EISC_TRIG_RST = 12'h000;
  localparam logic [EISC_PINS-1:0] EISC_PIN_RST = 6'h00;

  // AXI responses
  localparam logic [1:0] EISC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EISC_RESP_SLVERR = 2'h2;

  // Trigger codes
  typedef enum logic [1:0] {
    EISC_LOW = 2'h0,
    EISC_FALL = 2'h1,
    EISC_RISE = 2'h2,
    EISC_BOTH = 2'h3
  } eisc_sense_t;

  // Read answer carrier
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } eisc_rd_t;

endpackage

// ### sim/eisc_pin_src.sv
// Model of the external sources that drive the six interrupt pins.
// Assumes the bench commands levels; pins change just after aclk edges.
`timescale 1ns/1ps
module eisc_pin_src
  import eisc_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Commanded levels and pins
  input wire logic [EISC_PINS-1:0] level_cmd,
  output logic [EISC_PINS-1:0] pin_q
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Pins idle high so no edge is seen before a source is commanded
  initial pin_q = 6'h3F;
  // Plain always: the start-up value above is a second writer of pin_q
  always @(posedge aclk) begin
    pin_q <= level_cmd;
  end
endmodule

// ### sim/ext_irq_sense_status_bench.sv
// Bench for the pin sense block: register tests over AXI4-Lite.
// Assumes the pin source model and the design package are compiled first.
`timescale 1ns/1ps
module ext_irq_sense_status_bench
  import eisc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 0, aresetn = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, arready;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, r;
  logic bvalid, rvalid;
  logic [5:0] lvl = 6'h3F, pins, ack = 0, req;
  logic irq;
  logic [31:0] d;
  int mismatches = 0, n_compared = 0;

  always #4 aclk = ~aclk;

  eisc_pin_src src (.aclk(aclk), .level_cmd(lvl), .pin_q(pins));

  eisc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ext_int_pin(pins),
    .handling_ack(ack), .pin_request_q(req), .irq_q(irq));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Ready lines are held high, so each answer is taken when it shows
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Handling pulse for the given pins, one cycle wide
  task automatic pulse(input logic [5:0] m);
    ack <= m;
    @(posedge aclk);
    ack <= 6'h00;
    repeat (2) @(posedge aclk);
  endtask

  // Source model, input sample and flag each add one cycle
  task automatic drive(input logic [5:0] v);
    lvl <= v;
    repeat (4) @(posedge aclk);
  endtask

  task automatic final_report;
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(EISC_OFS_TRIG);
    chk(d, 32'h0);
    chk(r, EISC_RESP_OKAY);
    rd(EISC_OFS_FLAGS);
    chk(d, 32'h0);
    wr(4'h2, 32'h1);
    chk(r, EISC_RESP_SLVERR);
    // Unmapped read answers an error with zero data
    rd(4'h2);
    chk(d, 32'h0);
    chk(r, EISC_RESP_SLVERR);
    // Pin0 low, 1 and 4 falling, 2 and 5 rising, 3 both edges
    wr(EISC_OFS_TRIG, 32'h0000_09E4);
    chk(r, EISC_RESP_OKAY);
    rd(EISC_OFS_TRIG);
    chk(d, 32'h0000_09E4);
    drive(6'h00);
    rd(EISC_OFS_FLAGS);
    chk(d, 32'h1B);
    // Writing ones does nothing and drops the read arming
    wr(EISC_OFS_FLAGS, 32'h3F);
    drive(6'h3F);
    wr(EISC_OFS_FLAGS, 32'h0);
    rd(EISC_OFS_FLAGS);
    chk(d, 32'h3F);
    wr(EISC_OFS_FLAGS, 32'h0);
    rd(EISC_OFS_FLAGS);
    chk(d, 32'h0);
    // Handling clears edge flags; low-level pin0 is still low
    drive(6'h00);
    pulse(6'h3F);
    rd(EISC_OFS_FLAGS);
    chk(d, 32'h01);
    drive(6'h3F);
    rd(EISC_OFS_FLAGS);
    chk(d, 32'h2D);
    // Requests need enables; summary line follows the mask
    chk(req, 32'h0);
    chk(irq, 32'h0);
    wr(EISC_OFS_ENAB, 32'h3F);
    repeat (2) @(posedge aclk);
    chk(req, 32'h2D);
    wr(EISC_OFS_MASK, 32'h04);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h1);
    // Pin0 now high, so handling clears the low-level flag too
    pulse(6'h3F);
    @(posedge aclk);
    chk(req, 32'h0);
    chk(irq, 32'h0);
    rd(EISC_OFS_FLAGS);
    chk(d, 32'h0);
    final_report();
  end
endmodule
